//--- inc/ccib_cfg.svh
// address map, field positions, reset values and timing counts
`ifndef CCIB_CFG_SVH
`define CCIB_CFG_SVH
`define CCIB_ADDR_CFG 8'h07
`define CCIB_ADDR_ON1 8'h08
`define CCIB_ADDR_PER1 8'h09
`define CCIB_ADDR_ON2 8'h0A
`define CCIB_ADDR_PER2 8'h0B
`define CCIB_RST_CFG 8'h1B
`define CCIB_RST_LED 8'h00
`define CCIB_B_AUTO 7
`define CCIB_B_RESTART 6
`define CCIB_B_TIMER 5
`define CCIB_B_CUR_HI 4
`define CCIB_B_CUR_LO 3
`define CCIB_B_USB500 2
`define CCIB_B_USB_OK 1
`define CCIB_B_CHG_EN 0
`define CCIB_B_MODE 7
`define CCIB_CLK_HZ 50000000
`define CCIB_TICK_MS 10
`define CCIB_TICK_CYC (`CCIB_CLK_HZ / 1000 * `CCIB_TICK_MS)
`define CCIB_PER_TICKS 10
`endif

//--- inc/ccib_pkg.sv
// types shared by the charger configuration block
package ccib_pkg;
    typedef enum logic [1:0] {
        CCIB_CUR_25 = 2'b00,
        CCIB_CUR_50 = 2'b01,
        CCIB_CUR_75 = 2'b10,
        CCIB_CUR_FULL = 2'b11
    } ccib_cur_e;
    typedef enum logic [1:0] {
        CCIB_SRC_NONE = 2'b00,
        CCIB_SRC_AC = 2'b01,
        CCIB_SRC_USB = 2'b10
    } ccib_src_e;
    typedef logic [7:0] ccib_byte_t;
endpackage : ccib_pkg

//--- hdl/ccib_blinker.sv
// one indicator blinker: on-time in 10 ms steps, period in 100 ms steps
`timescale 1ns/1ps
`include "ccib_cfg.svh"
module ccib_blinker (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic tick,
    input wire logic run,
    input wire logic [6:0] on_time,
    input wire logic [6:0] period,
    output logic lit
);
    import ccib_pkg::*;
    logic [10:0] cnt_r;
    logic [10:0] cnt_nxt;
    logic lit_r;
    logic lit_nxt;
    wire [10:0] per_ticks = 11'(period) * 11'(`CCIB_PER_TICKS);
    // a zero field still gives one step, the least on-time and period
    wire [10:0] per_len = (per_ticks == 11'h000) ? 11'(`CCIB_PER_TICKS)
                                                 : per_ticks;
    wire [10:0] on_len = (on_time == 7'h00) ? 11'h001 : 11'(on_time);
    wire wrap = (cnt_r + 11'h001 >= per_len);
    always_comb begin
        cnt_nxt = cnt_r;
        lit_nxt = lit_r;
        if (!run) begin
            cnt_nxt = 11'h000;
            lit_nxt = 1'b0;
        end else if (tick) begin
            cnt_nxt = wrap ? 11'h000 : cnt_r + 11'h001;
            lit_nxt = wrap ? 1'b1 : (cnt_r + 11'h001 < on_len);
        end else if (cnt_r == 11'h000 && !lit_r) begin
            lit_nxt = 1'b1;
        end
    end
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cnt_r <= 11'h000;
            lit_r <= 1'b0;
        end else if (clk_en) begin
            cnt_r <= cnt_nxt;
            lit_r <= lit_nxt;
        end
    end
    assign lit = lit_r;
endmodule : ccib_blinker

//--- hdl/ccib_top.sv
// charger configuration register and two indicator blinkers
// Behaviour
// - with auto-start inhibit clear, a valid source and supply above undervoltage force on and disable wait.
// - with auto-start inhibit set, a present source enables wait and does not force the converters on.
// - while the restart bit is set, all charger timers are cleared and charging restarts.
// - with the timer bit clear, the fast-charge timer is off and status bit 3 shows the taper comparator.
// - with the timer bit set, both timers run unless the restart bit is set, and status bit 3 shows the taper timer.
// - the two current bits select 25, 50, 75 percent or full of the set current.
// - bit 2 picks a 100 mA or 500 mA USB limit and is ignored when USB charging is off.
// - bit 1 clear forbids charging from USB, set allows it.
// - bit 0 gates all charging and AC is preferred when both sources are valid.
// - first indicator modes are charger control, blink, off and always on.
// - first indicator on-time is in 10 ms steps with a 10 ms minimum.
// - first indicator period is in 100 ms steps with a 100 ms minimum.
// - second indicator modes are off, blink, off and always on.
// - second indicator on-time is in 10 ms steps with a 10 ms minimum.
// - second indicator period is in 100 ms steps with a 100 ms minimum.
`timescale 1ns/1ps
`include "ccib_cfg.svh"
module ccib_top (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire ccib_pkg::ccib_byte_t reg_wdata,
    output ccib_pkg::ccib_byte_t reg_rdata,
    input wire logic ac_valid,
    input wire logic usb_valid,
    input wire logic vcc_above_uvlo,
    input wire logic charger_indicator_req,
    input wire logic taper_cmp,
    input wire logic taper_timer_done,
    output logic force_on,
    output logic wait_enable,
    output logic charger_timers_clear,
    output logic fast_timer_en,
    output logic taper_timer_en,
    output logic taper_status,
    output ccib_pkg::ccib_cur_e charge_current_select,
    output logic usb_limit_500ma,
    output ccib_pkg::ccib_src_e charge_source,
    output logic charge_indicator_output_o,
    output logic charge_indicator_output_oe,
    output logic second_indicator_output_o,
    output logic second_indicator_output_oe
);
    import ccib_pkg::*;
    ccib_byte_t cfg_r;
    ccib_byte_t on1_r;
    ccib_byte_t per1_r;
    ccib_byte_t on2_r;
    ccib_byte_t per2_r;
    ccib_byte_t rdata_r;
    logic [18:0] tick_cnt_r;
    logic tick;
    logic blink1;
    logic blink2;

    wire wr_cfg = reg_wr && reg_addr == `CCIB_ADDR_CFG;
    wire wr_on1 = reg_wr && reg_addr == `CCIB_ADDR_ON1;
    wire wr_per1 = reg_wr && reg_addr == `CCIB_ADDR_PER1;
    wire wr_on2 = reg_wr && reg_addr == `CCIB_ADDR_ON2;
    wire wr_per2 = reg_wr && reg_addr == `CCIB_ADDR_PER2;

    // restart bit is a plain level held by software, not a pulse
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cfg_r <= `CCIB_RST_CFG;
            on1_r <= `CCIB_RST_LED;
            per1_r <= `CCIB_RST_LED;
            on2_r <= `CCIB_RST_LED;
            per2_r <= `CCIB_RST_LED;
        end else if (clk_en) begin
            if (wr_cfg) cfg_r <= reg_wdata;
            if (wr_on1) on1_r <= reg_wdata;
            if (wr_per1) per1_r <= reg_wdata;
            if (wr_on2) on2_r <= reg_wdata;
            if (wr_per2) per2_r <= reg_wdata;
        end
    end

    wire [7:0] rd_mux =
        (reg_addr == `CCIB_ADDR_CFG) ? cfg_r :
        (reg_addr == `CCIB_ADDR_ON1) ? on1_r :
        (reg_addr == `CCIB_ADDR_PER1) ? per1_r :
        (reg_addr == `CCIB_ADDR_ON2) ? on2_r :
        (reg_addr == `CCIB_ADDR_PER2) ? per2_r : 8'h00;
    always_ff @(posedge mclk) begin
        if (sys_rst) rdata_r <= 8'h00;
        else if (clk_en) rdata_r <= rd_mux;
    end
    assign reg_rdata = rdata_r;

    // charger controls
    wire auto_inh = cfg_r[`CCIB_B_AUTO];
    wire src_ok = ac_valid || usb_valid;
    wire timer_on = cfg_r[`CCIB_B_TIMER];
    wire chg_en = cfg_r[`CCIB_B_CHG_EN];
    wire usb_ok = cfg_r[`CCIB_B_USB_OK];
    assign force_on = !auto_inh && src_ok && vcc_above_uvlo;
    assign wait_enable = auto_inh;
    assign charger_timers_clear = cfg_r[`CCIB_B_RESTART];
    assign fast_timer_en = timer_on && !cfg_r[`CCIB_B_RESTART];
    assign taper_timer_en = fast_timer_en;
    assign taper_status = timer_on ? taper_timer_done : taper_cmp;
    assign charge_current_select =
        ccib_cur_e'({cfg_r[`CCIB_B_CUR_HI], cfg_r[`CCIB_B_CUR_LO]});
    assign usb_limit_500ma = usb_ok && cfg_r[`CCIB_B_USB500];
    assign charge_source = !chg_en ? CCIB_SRC_NONE :
                           ac_valid ? CCIB_SRC_AC :
                           (usb_valid && usb_ok) ? CCIB_SRC_USB :
                           CCIB_SRC_NONE;

    // 10 ms time base shared by both blinkers
    always_ff @(posedge mclk) begin
        if (sys_rst) tick_cnt_r <= 19'h00000;
        else if (clk_en) tick_cnt_r <= tick ? 19'h00000
                                            : tick_cnt_r + 19'h00001;
    end
    assign tick = (tick_cnt_r == 19'(`CCIB_TICK_CYC - 1));

    wire [1:0] mode1 = {on1_r[`CCIB_B_MODE], per1_r[`CCIB_B_MODE]};
    wire [1:0] mode2 = {on2_r[`CCIB_B_MODE], per2_r[`CCIB_B_MODE]};

    ccib_blinker u_blink1 (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .tick(tick),
        .run(mode1 == 2'b01),
        .on_time(on1_r[6:0]),
        .period(per1_r[6:0]),
        .lit(blink1)
    );
    ccib_blinker u_blink2 (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .tick(tick),
        .run(mode2 == 2'b01),
        .on_time(on2_r[6:0]),
        .period(per2_r[6:0]),
        .lit(blink2)
    );

    // open drain: the pin is pulled low only while lit
    wire pg_lit = (mode1 == 2'b00) ? charger_indicator_req :
                  (mode1 == 2'b01) ? blink1 :
                  (mode1 == 2'b11);
    wire second_indicator_output_lit = (mode2 == 2'b01) ? blink2 : (mode2 == 2'b11);
    assign charge_indicator_output_o = 1'b0;
    assign charge_indicator_output_oe = pg_lit;
    assign second_indicator_output_o = 1'b0;
    assign second_indicator_output_oe = second_indicator_output_lit;

    property p_force_on;
        @(posedge mclk) disable iff (sys_rst)
        (!auto_inh && src_ok && vcc_above_uvlo) |-> force_on && !wait_enable;
    endproperty
    a_force_on: assert property (p_force_on)
        else $error("force on missing");
    property p_wait;
        @(posedge mclk) disable iff (sys_rst)
        (auto_inh && src_ok) |-> wait_enable && !force_on;
    endproperty
    a_wait: assert property (p_wait)
        else $error("wait mode not enabled");
    property p_restart;
        @(posedge mclk) disable iff (sys_rst)
        cfg_r[`CCIB_B_RESTART] |-> charger_timers_clear && !fast_timer_en;
    endproperty
    a_restart: assert property (p_restart)
        else $error("timers not cleared on restart");
    property p_taper;
        @(posedge mclk) disable iff (sys_rst)
        !timer_on |-> !fast_timer_en && taper_status == taper_cmp;
    endproperty
    a_taper: assert property (p_taper)
        else $error("taper status source wrong");
    property p_cur_sel;
        @(posedge mclk) disable iff (sys_rst)
        charge_current_select == cfg_r[`CCIB_B_CUR_HI:`CCIB_B_CUR_LO];
    endproperty
    a_cur_sel: assert property (p_cur_sel)
        else $error("charge current select wrong");
    property p_usb_lim;
        @(posedge mclk) disable iff (sys_rst)
        usb_ok |-> usb_limit_500ma == cfg_r[`CCIB_B_USB500];
    endproperty
    a_usb_lim: assert property (p_usb_lim)
        else $error("usb limit wrong");
    property p_usb_block;
        @(posedge mclk) disable iff (sys_rst)
        !usb_ok |-> charge_source != CCIB_SRC_USB && !usb_limit_500ma;
    endproperty
    a_usb_block: assert property (p_usb_block)
        else $error("usb charging not blocked");
    property p_chg_gate;
        @(posedge mclk) disable iff (sys_rst)
        (chg_en && ac_valid) |-> charge_source == CCIB_SRC_AC;
    endproperty
    a_chg_gate: assert property (p_chg_gate)
        else $error("ac source not preferred");
    property p_pg_on;
        @(posedge mclk) disable iff (sys_rst)
        (mode1 == 2'b11) |-> charge_indicator_output_oe;
    endproperty
    a_pg_on: assert property (p_pg_on)
        else $error("first indicator not held on");
    property p_pg_off;
        @(posedge mclk) disable iff (sys_rst)
        (mode1 == 2'b10) |-> !charge_indicator_output_oe;
    endproperty
    a_pg_off: assert property (p_pg_off)
        else $error("first indicator not off");
    property p_second_indicator_output_off;
        @(posedge mclk) disable iff (sys_rst)
        (mode2 == 2'b10 || mode2 == 2'b00) |-> !second_indicator_output_oe;
    endproperty
    a_second_indicator_output_off: assert property (p_second_indicator_output_off)
        else $error("second indicator not off");
endmodule : ccib_top

//--- sim/ccib_top_bench.sv
// self-checking bench for the charger configuration and blinker block
`timescale 1ns/1ps
module ccib_top_bench;
    import ccib_pkg::*;
    logic mclk, sys_rst, clk_en, reg_wr, ac, usb, vcc, req, tcmp, tdone;
    logic [7:0] addr;
    ccib_byte_t wdata, rdata, rv, c;
    ccib_byte_t led_r [4];
    logic force_on, wait_en, tclr, fast_en, taper_en, tstat, u500;
    ccib_cur_e cur;
    ccib_src_e src;
    logic pg_o, pg_oe, l2_o, l2_oe;
    int bad_count, num_checks;
    logic [31:0] seed;
    ccib_top ccib_top_i (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en),
        .reg_wr(reg_wr), .reg_addr(addr), .reg_wdata(wdata),
        .reg_rdata(rdata), .ac_valid(ac), .usb_valid(usb),
        .vcc_above_uvlo(vcc), .charger_indicator_req(req),
        .taper_cmp(tcmp), .taper_timer_done(tdone), .force_on(force_on),
        .wait_enable(wait_en), .charger_timers_clear(tclr),
        .fast_timer_en(fast_en), .taper_timer_en(taper_en),
        .taper_status(tstat), .charge_current_select(cur),
        .usb_limit_500ma(u500), .charge_source(src),
        .charge_indicator_output_o(pg_o), .charge_indicator_output_oe(pg_oe),
        .second_indicator_output_o(l2_o), .second_indicator_output_oe(l2_oe));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    // ac wins over usb; usb only counts when its charging is allowed
    function automatic logic [1:0] exp_src(input ccib_byte_t k);
        if (!k[0]) return 2'h0;
        if (ac) return 2'h1;
        if (usb && k[1]) return 2'h2;
        return 2'h0;
    endfunction : exp_src
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : report_and_stop
    task automatic chk8(input logic [7:0] g, input logic [7:0] e,
                        input string m);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk8
    task automatic chk1(input logic g, input logic e, input string m);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch at %0t: %s got %b", $time, m, g);
        end
    endtask : chk1
    task automatic wr(input logic [7:0] a, input ccib_byte_t d);
        @(posedge mclk);
        #1 reg_wr = 1'b1;
        addr = a;
        wdata = d;
        @(posedge mclk);
        #1 reg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output ccib_byte_t d);
        @(posedge mclk);
        #1 addr = a;
        @(posedge mclk);
        #1 d = rdata;
    endtask : rd
    task automatic check_cfg(input ccib_byte_t k);
        chk1(force_on, !k[7] & (ac | usb) & vcc, "force on");
        chk1(wait_en, k[7], "wait enable");
        chk1(tclr, k[6], "timer clear");
        chk1(fast_en, k[5] & !k[6], "fast timer");
        if (!k[6]) chk1(taper_en, k[5], "taper timer");
        chk1(tstat, k[5] ? tdone : tcmp, "taper status");
        chk8({6'h00, cur}, {6'h00, k[4:3]}, "current");
        if (k[1]) chk1(u500, k[2], "usb limit");
        chk8({6'h00, src}, {6'h00, exp_src(k)}, "source");
    endtask : check_cfg
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    initial begin
        seed = 32'h0000FD1F;
        {ac, usb, vcc, req, tcmp, tdone, reg_wr} = 7'h00;
        addr = 8'h00;
        wdata = 8'h00;
        clk_en = 1'b1;
        sys_rst = 1'b1;
        repeat (3) @(posedge mclk);
        #1 sys_rst = 1'b0;
        rd(8'h07, rv);
        chk8(rv, 8'h1B, "config reset");
        check_cfg(8'h1B);
        chk1(pg_oe, req, "charger controls first output");
        chk1(l2_oe, 1'b0, "second output off");
        // 0C is unmapped and must read as zero
        for (int k = 1; k < 6; k++) begin
            rd(8'h07 + k[7:0], rv);
            chk8(rv, 8'h00, "led reset");
        end
        $display("reset test done");
        for (int i = 0; i < 24; i++) begin
            c = (i < 4) ? 8'h40 >> (2 * i) : 8'(xs());
            {ac, usb, vcc, tcmp, tdone} = 5'(xs());
            wr(8'h07, c);
            rd(8'h07, rv);
            chk8(rv, c, "config readback");
            check_cfg(c);
        end
        $display("config test done");
        // restart bit must not clear itself while left set
        wr(8'h07, 8'h7B);
        repeat (40) @(posedge mclk);
        chk1(tclr, 1'b1, "restart held");
        wr(8'h07, 8'h3B);
        chk1(tclr, 1'b0, "restart released");
        clk_en = 1'b0;
        wr(8'h07, 8'hA5);
        clk_en = 1'b1;
        rd(8'h07, rv);
        chk8(rv, 8'h3B, "frozen write");
        $display("restart test done");
        for (int m = 0; m < 4; m++) begin
            req = 1'(xs());
            for (int k = 0; k < 4; k++) begin
                led_r[k] = {k[0] ? m[0] : m[1], 7'(xs() | 32'h1)};
                wr(8'h08 + k[7:0], led_r[k]);
            end
            for (int k = 0; k < 4; k++) begin
                rd(8'h08 + k[7:0], rv);
                chk8(rv, led_r[k], "led readback");
            end
            // blink starts lit at its period start and stays lit far
            // below the 10 ms minimum on-time
            repeat (200) @(posedge mclk);
            chk1(pg_oe, m == 0 ? req : m != 2, "first mode");
            chk1(l2_oe, m[0], "second mode");
            chk1(pg_o | l2_o, 1'b0, "open drain low");
        end
        $display("indicator test done");
        report_and_stop();
    end
endmodule : ccib_top_bench
